// ---- src/rtcmir_pkg.sv ----
// Constants for the calendar alias and elapsed-seconds register window
package rtcmir_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_SECONDS = 8'h00;
	localparam logic [7:0] IDX_MINUTES = 8'h01;
	localparam logic [7:0] IDX_HOURS = 8'h02;
	localparam logic [7:0] IDX_WEEKDAY = 8'h03;
	localparam logic [7:0] IDX_DAY = 8'h04;
	localparam logic [7:0] IDX_MONTH = 8'h05;
	localparam logic [7:0] IDX_YEAR = 8'h06;
	localparam logic [7:0] IDX_FRAC_LOW = 8'h10;
	localparam logic [7:0] IDX_FRAC_HIGH = 8'h11;
	localparam logic [7:0] IDX_SECONDS_ALIAS = 8'h12;
	localparam logic [7:0] IDX_MINUTES_ALIAS = 8'h13;
	localparam logic [7:0] IDX_HOURS_ALIAS = 8'h14;
	localparam logic [7:0] IDX_WEEKDAY_ALIAS = 8'h15;
	localparam logic [7:0] IDX_DAY_ALIAS = 8'h16;
	localparam logic [7:0] IDX_MONTH_ALIAS = 8'h17;
	localparam logic [7:0] IDX_YEAR_ALIAS = 8'h18;
	localparam logic [7:0] IDX_ACCESS_SELECT = 8'h1F;
	// Writable-bit masks; all other bits read zero and ignore writes
	localparam logic [7:0] MASK_SECONDS = 8'h7F;
	localparam logic [7:0] MASK_MINUTES = 8'h7F;
	localparam logic [7:0] MASK_HOURS = 8'h3F;
	localparam logic [7:0] MASK_WEEKDAY = 8'h7F;
	localparam logic [7:0] MASK_DAY = 8'h3F;
	localparam logic [7:0] MASK_MONTH = 8'h1F;
	localparam logic [7:0] MASK_YEAR = 8'hFF;
	localparam logic [7:0] MASK_SELECT = 8'h07;
	// Field positions
	localparam int FRAC_LOW_POS = 6;
	localparam int SEL_DECIMAL_BIT = 2;
	localparam int SEL_BIN_EN_BIT = 1;
	localparam int SEL_BCD_EN_BIT = 0;
	// Binary-view select codes
	localparam logic [2:0] SEL_BIN_RUN = 3'h3;
	localparam logic [2:0] SEL_BIN_IDLE = 3'h2;
	// Reset values
	localparam logic [7:0] RST_SECONDS = 8'h00;
	localparam logic [7:0] RST_MINUTES = 8'h00;
	localparam logic [7:0] RST_HOURS = 8'h00;
	localparam logic [7:0] RST_WEEKDAY = 8'h01;
	localparam logic [7:0] RST_DAY = 8'h01;
	localparam logic [7:0] RST_MONTH = 8'h01;
	localparam logic [7:0] RST_YEAR = 8'h00;
	localparam logic [2:0] RST_SELECT = 3'h7;
	localparam logic [9:0] RST_FRACTION = 10'h000;
	localparam logic [32:0] RST_ELAPSED = 33'h000000000;
	// Calendar limits in BCD
	localparam logic [7:0] LAST_SECOND = 8'h59;
	localparam logic [7:0] LAST_HOUR = 8'h23;
	localparam logic [7:0] LAST_DAY = 8'h31;
	localparam logic [7:0] LAST_MONTH = 8'h12;
	localparam logic [7:0] LAST_YEAR = 8'h99;
	// Timing: one fraction step is 1/1024 s
	localparam int CLK_HZ = 200000000;
	localparam int FRACTION_HZ = 1024;
	localparam int FRACTION_CYCLES = CLK_HZ / FRACTION_HZ;
endpackage : rtcmir_pkg

// ---- src/rtcmir_regs.sv ----
// APB register block: calendar aliases and 33-bit elapsed-seconds counter
// Functional notes
// - Calendar view: 0x12 is the seconds register
// - Seconds alias write keeps fraction counter running
// - 0x13 minutes alias, bit 7 read-only
// - 0x14 hours alias, bits 7:6 read-only
// - 0x15 weekday alias, seven bits, bit 7 read-only
// - 0x16 day alias, upper bits read-only
// - 0x17 month alias, bits 7:5 read-only
// - 0x18 year alias, all eight bits writable
// - Binary view: elapsed counter set/read at 0x12-0x16
// - Elapsed counter bytes little-endian from 0x12
// - Counter is 33 bits; bit 32 at 0x16
// - Elapsed writes never clear the fraction counter
// - Binary view only when select is 0x3/0x2
// - Decimal select bit: 1 calendar, 0 binary; codes 0x0 and 0x1 keep the calendar view here
// - Primary seconds write clears fraction counter
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module rtcmir_regs #(
	parameter int ADDR_W = 12,
	parameter int TICK_CYCLES = rtcmir_pkg::FRACTION_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic second_tick
);
	import rtcmir_pkg::*;

	// Refuse settings the decoder or the prescaler cannot serve
	generate
		if (ADDR_W < 11 || ADDR_W > 32) begin : g_bad_addr
			$error("rtcmir_regs: ADDR_W must be 11 to 32");
		end
		if (TICK_CYCLES < 1) begin : g_bad_tick
			$error("rtcmir_regs: TICK_CYCLES must be at least 1");
		end
	endgenerate

	localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

	// BCD increment with wrap; returns {carry, value}
	function automatic logic [8:0] bcd_inc(input logic [7:0] v,
		input logic [7:0] last, input logic [7:0] first);
		logic [8:0] r;
		r = {1'b0, v};
		if (v == last) begin
			r = {1'b1, first};
		end else if (v[3:0] == 4'h9) begin
			r = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {1'b0, v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction : bcd_inc

	// Calendar field write: its primary index, or its alias when allowed
	function automatic logic cal_hit(input logic [7:0] i,
		input logic [7:0] primary, input logic [7:0] alias_idx,
		input logic alias_ok);
		return (i == primary) || (i == alias_idx && alias_ok);
	endfunction : cal_hit

	logic [7:0] seconds;
	logic [7:0] minutes;
	logic [7:0] hours;
	logic [7:0] weekday;
	logic [7:0] day;
	logic [7:0] month;
	logic [7:0] year;
	logic [9:0] fraction;
	logic [31:0] presc;
	logic [32:0] elapsed_count;
	logic [2:0] counter_access_select;

	logic [7:0] idx;
	logic addr_ok;
	logic acc_done;
	logic wr;
	logic bin_view;
	logic frac_step;
	logic sec_step;
	logic [7:0] wbyte;
	logic [7:0] rd_byte;

	// Decode; upper address bits and low two bits must be zero
	assign idx = paddr[9:2];
	assign acc_done = psel & penable & pready;
	assign wr = acc_done & pwrite & addr_ok & pstrb[0];
	assign wbyte = pwdata[7:0];

	// Binary view only for select codes 0x3 and 0x2
	// Codes 0x0 and 0x1 keep the calendar view although bit 2 is clear
	assign bin_view = (counter_access_select == SEL_BIN_RUN) ||
		(counter_access_select == SEL_BIN_IDLE);

	// Fraction ticks every TICK_CYCLES; a second passes on its wrap
	assign frac_step = (presc == TICK_LAST);
	assign sec_step = frac_step && (fraction == 10'h3FF);

	// Write strobes per target
	logic wr_sec_primary;
	logic wr_sec_alias;
	logic wr_min;
	logic wr_hour;
	logic wr_week;
	logic wr_day;
	logic wr_month;
	logic wr_year;
	logic [4:0] wr_bin;

	assign wr_sec_primary = wr && idx == IDX_SECONDS;
	assign wr_sec_alias = wr && idx == IDX_SECONDS_ALIAS && !bin_view;
	assign wr_min = wr &&
		cal_hit(idx, IDX_MINUTES, IDX_MINUTES_ALIAS, !bin_view);
	assign wr_hour = wr &&
		cal_hit(idx, IDX_HOURS, IDX_HOURS_ALIAS, !bin_view);
	assign wr_week = wr &&
		cal_hit(idx, IDX_WEEKDAY, IDX_WEEKDAY_ALIAS, !bin_view);
	assign wr_day = wr &&
		cal_hit(idx, IDX_DAY, IDX_DAY_ALIAS, !bin_view);
	assign wr_month = wr &&
		cal_hit(idx, IDX_MONTH, IDX_MONTH_ALIAS, 1'b1);
	assign wr_year = wr &&
		cal_hit(idx, IDX_YEAR, IDX_YEAR_ALIAS, 1'b1);

	// One strobe per elapsed-count byte, 0x12 upward
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			wr_bin[i] = wr && bin_view &&
				idx == IDX_SECONDS_ALIAS + 8'(i);
		end
	end

	// Calendar advance, carried field by field
	// Day wraps 31 to 01 in every month; there is no leap-year logic
	logic [8:0] adv_sec;
	logic [8:0] adv_min;
	logic [8:0] adv_hour;
	logic [8:0] adv_day;
	logic [8:0] adv_month;
	logic [8:0] adv_year;
	logic [7:0] adv_week;

	always_comb begin
		adv_sec = bcd_inc(seconds, LAST_SECOND, 8'h00);
		adv_min = adv_sec[8] ? bcd_inc(minutes, LAST_SECOND, 8'h00) :
			{1'b0, minutes};
		adv_hour = adv_min[8] ? bcd_inc(hours, LAST_HOUR, 8'h00) :
			{1'b0, hours};
		adv_day = adv_hour[8] ? bcd_inc(day, LAST_DAY, 8'h01) :
			{1'b0, day};
		adv_month = adv_day[8] ? bcd_inc(month, LAST_MONTH, 8'h01) :
			{1'b0, month};
		adv_year = adv_month[8] ? bcd_inc(year, LAST_YEAR, 8'h00) :
			{1'b0, year};
		// Weekday is one-hot over seven bits and rotates at midnight
		adv_week = weekday;
		if (adv_hour[8]) begin
			adv_week = {1'b0, weekday[5:0], weekday[6]};
		end
	end

	logic cal_step;
	assign cal_step = sec_step && counter_access_select[SEL_BCD_EN_BIT];

	// Calendar fields, one process each; a write to a field wins over
	// the advance of that field in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seconds <= RST_SECONDS;
		end else if (wr_sec_primary || wr_sec_alias) begin
			seconds <= wbyte & MASK_SECONDS;
		end else if (cal_step) begin
			seconds <= adv_sec[7:0];
		end
	end

	// Minutes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			minutes <= RST_MINUTES;
		end else if (wr_min) begin
			minutes <= wbyte & MASK_MINUTES;
		end else if (cal_step) begin
			minutes <= adv_min[7:0];
		end
	end

	// Hours
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hours <= RST_HOURS;
		end else if (wr_hour) begin
			hours <= wbyte & MASK_HOURS;
		end else if (cal_step) begin
			hours <= adv_hour[7:0];
		end
	end

	// Weekday; software may write a pattern that is not one-hot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			weekday <= RST_WEEKDAY;
		end else if (wr_week) begin
			weekday <= wbyte & MASK_WEEKDAY;
		end else if (cal_step) begin
			weekday <= adv_week;
		end
	end

	// Day of month
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			day <= RST_DAY;
		end else if (wr_day) begin
			day <= wbyte & MASK_DAY;
		end else if (cal_step) begin
			day <= adv_day[7:0];
		end
	end

	// Month
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			month <= RST_MONTH;
		end else if (wr_month) begin
			month <= wbyte & MASK_MONTH;
		end else if (cal_step) begin
			month <= adv_month[7:0];
		end
	end

	// Year, all eight bits writable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			year <= RST_YEAR;
		end else if (wr_year) begin
			year <= wbyte & MASK_YEAR;
		end else if (cal_step) begin
			year <= adv_year[7:0];
		end
	end

	// Prescaler; only the primary seconds write restarts it, so alias
	// and elapsed writes keep the phase of the running second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc <= 32'h00000000;
		end else if (wr_sec_primary || frac_step) begin
			presc <= 32'h00000000;
		end else begin
			presc <= presc + 32'h00000001;
		end
	end

	// Fraction counter; a write to its own bytes wins over the step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fraction <= RST_FRACTION;
		end else if (wr_sec_primary) begin
			fraction <= RST_FRACTION;
		end else if (wr && idx == IDX_FRAC_LOW) begin
			fraction[1:0] <= wbyte[FRAC_LOW_POS +: 2];
		end else if (wr && idx == IDX_FRAC_HIGH) begin
			fraction[9:2] <= wbyte;
		end else if (frac_step) begin
			fraction <= fraction + 10'h001;
		end
	end

	// Elapsed-seconds counter; a byte write replaces only that byte
	// Bytes are not latched together: a carry between two byte reads
	// can tear the value, so software reads the bytes twice
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			elapsed_count <= RST_ELAPSED;
		end else if (|wr_bin) begin
			for (int i = 0; i < 4; i++) begin
				if (wr_bin[i]) begin
					elapsed_count[8*i +: 8] <= wbyte;
				end
			end
			if (wr_bin[4]) begin
				elapsed_count[32] <= wbyte[0];
			end
		end else if (sec_step && counter_access_select[SEL_BIN_EN_BIT]) begin
			elapsed_count <= elapsed_count + 33'h000000001;
		end
	end

	// Access select register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_access_select <= RST_SELECT;
		end else if (wr && idx == IDX_ACCESS_SELECT) begin
			counter_access_select <= wbyte[2:0];
		end
	end

	// Read mux; addresses outside the map are errors
	always_comb begin
		rd_byte = 8'h00;
		addr_ok = 1'b1;
		case (idx)
			IDX_SECONDS: rd_byte = seconds;
			IDX_MINUTES: rd_byte = minutes;
			IDX_HOURS: rd_byte = hours;
			IDX_WEEKDAY: rd_byte = weekday;
			IDX_DAY: rd_byte = day;
			IDX_MONTH: rd_byte = month;
			IDX_YEAR: rd_byte = year;
			IDX_FRAC_LOW: rd_byte = {fraction[1:0], 6'h00};
			IDX_FRAC_HIGH: rd_byte = fraction[9:2];
			IDX_SECONDS_ALIAS: begin
				rd_byte = bin_view ? elapsed_count[7:0] : seconds;
			end
			IDX_MINUTES_ALIAS: begin
				rd_byte = bin_view ? elapsed_count[15:8] : minutes;
			end
			IDX_HOURS_ALIAS: begin
				rd_byte = bin_view ? elapsed_count[23:16] : hours;
			end
			IDX_WEEKDAY_ALIAS: begin
				rd_byte = bin_view ? elapsed_count[31:24] : weekday;
			end
			IDX_DAY_ALIAS: begin
				rd_byte = bin_view ? {7'h00, elapsed_count[32]} : day;
			end
			IDX_MONTH_ALIAS: rd_byte = month;
			IDX_YEAR_ALIAS: rd_byte = year;
			IDX_ACCESS_SELECT: rd_byte = {5'h00, counter_access_select};
			default: addr_ok = 1'b0;
		endcase
		if (paddr[1:0] != 2'b00 || paddr[ADDR_W-1:10] != '0) begin
			addr_ok = 1'b0;
		end
	end

	// APB answer: one wait state, data and error captured with pready
	// Every answer loads prdata; writes and refused reads load zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= !addr_ok;
			prdata <= (addr_ok && !pwrite) ? {24'h000000, rd_byte} :
				32'h00000000;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// One-cycle marker of each whole second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			second_tick <= 1'b0;
		end else begin
			second_tick <= sec_step;
		end
	end
endmodule : rtcmir_regs

// ---- verif/rtcmir_chk.sv ----
// Port assertions for the alias and elapsed-seconds register block
`timescale 1ns/1ps
module rtcmir_chk #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic second_tick
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Read data moves only with an answer
	logic rd_done;
	assign rd_done = pready && !pwrite;
	chk_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no answer one cycle into access phase");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("answer outside access phase");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("answer longer than one cycle");
	chk_err_align: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned address not refused");
	chk_err_zero: assert property (rd_done && pslverr |-> prdata == 32'h0)
		else $error("refused read returned data");
	chk_upper_zero: assert property (rd_done |-> prdata[31:8] == 24'h0)
		else $error("read data above byte not zero");
	chk_data_hold: assert property (
		$changed(prdata) && $past(presetn) |-> pready)
		else $error("read data moved without an answer");
	chk_month_ro: assert property (
		rd_done && paddr[9:0] == 10'h05C |-> prdata[7:5] == 3'h0)
		else $error("month alias upper bits not zero");
	chk_select_ro: assert property (
		rd_done && paddr[9:0] == 10'h07C |-> prdata[7:3] == 5'h0)
		else $error("select upper bits not zero");
	chk_tick_pulse: assert property (second_tick |=> !second_tick [*8])
		else $error("second tick too long or too close");
	// Main scenarios reached
	cov_alias_read: cover property (rd_done && paddr[9:0] == 10'h048);
	cov_refused: cover property (pready && pslverr);
	cov_tick: cover property (second_tick);
endmodule : rtcmir_chk

bind rtcmir_regs rtcmir_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .second_tick(second_tick));

// ---- verif/rtcmir_host.sv ----
// Host processor model: APB master issuing register transfers
`timescale 1ns/1ps
module rtcmir_host #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb
);
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'h0;
	end
	// Setup, then hold everything until pready is sampled high
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] rdata, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Address and write data flip so stale values are never mistaken for live
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : rtcmir_host

// ---- verif/rtcmir_regs_test.sv ----
// Self-checking bench for the alias and elapsed-seconds window
`timescale 1ns/1ps
module rtcmir_regs_test;
	import rtcmir_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic second_tick, rd_err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic [3:0] pstrb;
	int errors = 0;
	int total_checks = 0;
	int ticks = 0;
	int t0 = 0;
	logic [7:0] rst_v [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
	logic [7:0] cal_w [7] = '{8'hD9, 8'hD9, 8'hE3, 8'h84, 8'hF1, 8'hF2, 8'h99};
	logic [7:0] cal_e [7] = '{8'h59, 8'h59, 8'h23, 8'h04, 8'h31, 8'h12, 8'h99};
	logic [7:0] bin_w [5] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hFF};
	logic [7:0] bin_e [5] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'h01};
	logic [7:0] sel_c [3] = '{8'h03, 8'h04, 8'h00};
	logic [7:0] sel_e [3] = '{8'hA1, 8'h30, 8'h30};
	// Four cycles per fraction step keeps a second at 4096 cycles
	rtcmir_regs #(.ADDR_W(12), .TICK_CYCLES(4)) uut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .second_tick(second_tick));
	rtcmir_host #(.ADDR_W(12)) u_host (.pclk(pclk), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// Count whole-second markers as the clock samples them
	always @(posedge pclk) begin
		if (second_tick === 1'b1) begin
			ticks++;
		end
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		u_host.xfer(1'b1, {2'b00, i, 2'b00}, {24'h0, d}, 4'hF, rd_data, rd_err);
	endtask : wr
	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		u_host.xfer(1'b0, {2'b00, i, 2'b00}, 32'h0, 4'h0, rd_data, rd_err);
		cmp(rd_data, {24'h0, e});
	endtask : rd
	// Fraction readback high byte must be at least the given floor
	task automatic frac_at_least(input logic [7:0] lo);
		u_host.xfer(1'b0, 12'h044, 32'h0, 4'h0, rd_data, rd_err);
		cmp({31'h0, rd_data[7:0] >= lo}, 32'h1);
	endtask : frac_at_least
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	// Hang guard, well beyond the expected run of some 4900 cycles
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		tally_and_finish();
	end
	initial begin
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 7; k++) rd(8'(8'h12 + k), rst_v[k]);
		rd(IDX_ACCESS_SELECT, 8'h07);
		$display("reset values done");
		// Calendar held still so written values stay put
		wr(IDX_ACCESS_SELECT, 8'h04);
		for (int k = 0; k < 7; k++) wr(8'(8'h12 + k), cal_w[k]);
		for (int k = 0; k < 7; k++) rd(8'(k), cal_e[k]);
		for (int k = 0; k < 7; k++) begin
			rd(8'(8'h12 + k), cal_e[k]);
		end
		$display("calendar alias done");
		wr(IDX_SECONDS, 8'h00);
		rd(IDX_FRAC_HIGH, 8'h00);
		repeat (200) @(posedge pclk);
		wr(IDX_SECONDS_ALIAS, 8'h30);
		frac_at_least(8'h0A);
		rd(IDX_SECONDS, 8'h30);
		$display("fraction clear done");
		wr(IDX_ACCESS_SELECT, {5'h00, SEL_BIN_IDLE});
		repeat (200) @(posedge pclk);
		for (int k = 0; k < 5; k++) wr(8'(8'h12 + k), bin_w[k]);
		frac_at_least(8'h14);
		for (int k = 0; k < 5; k++) rd(8'(8'h12 + k), bin_e[k]);
		rd(IDX_MONTH_ALIAS, 8'h12);
		rd(IDX_YEAR_ALIAS, 8'h99);
		for (int k = 0; k < 3; k++) begin
			wr(IDX_ACCESS_SELECT, sel_c[k]);
			rd(IDX_SECONDS_ALIAS, sel_e[k]);
		end
		$display("binary view done");
		u_host.xfer(1'b0, 12'h020, 32'h0, 4'h0, rd_data, rd_err);
		cmp({31'h0, rd_err}, 32'h1);
		u_host.xfer(1'b0, 12'h049, 32'h0, 4'h0, rd_data, rd_err);
		cmp({31'h0, rd_err}, 32'h1);
		u_host.xfer(1'b1, 12'h07C, 32'h7, 4'h0, rd_data, rd_err);
		rd(IDX_ACCESS_SELECT, 8'h00);
		wr(IDX_ACCESS_SELECT, 8'hFF);
		rd(IDX_ACCESS_SELECT, 8'h07);
		$display("refusals done");
		// Primary write restarts the fraction, so one second lands exactly
		wr(IDX_SECONDS, 8'h30);
		t0 = ticks;
		repeat (4200) @(posedge pclk);
		rd(IDX_SECONDS_ALIAS, 8'h31);
		cmp(32'(ticks - t0), 32'h1);
		// Elapsed count ran through that second as well
		wr(IDX_ACCESS_SELECT, 8'h03);
		rd(IDX_SECONDS_ALIAS, 8'hA2);
		$display("second advance done");
		tally_and_finish();
	end
endmodule : rtcmir_regs_test
